// ===== rtl/sysctl_regs.sv
// module: system id, wakeup timer and supply monitor register bank on apb
`timescale 1ns/10ps
`default_nettype none
module sysctl_regs
    import sysctl_pkg::*;
#(
    parameter logic [11:0] PART_CODE = 12'h5A3, // value arbitrary
    parameter logic [3:0] REVISION = 4'h1 // value arbitrary
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic slow_osc_clk,
    input wire logic trim_osc_clk,
    input wire logic low_voltage_detect,
    input wire logic stop_mode,
    output logic wakeup_irq,
    output logic supply_irq,
    output logic supply_reset_req,
    output logic supply_monitor_active,
    output logic bandgap_buffer_enable,
    output logic debug_pin_enable,
    output logic slow_osc_enable,
    output logic irq
);
    logic wr_en;
    logic rd_en;
    logic wk_flag_ff;
    logic wk_clksel_ff;
    logic wk_ie_ff;
    logic [2:0] wk_period_ff;
    logic sm_flag_ff;
    logic sm_ie_ff;
    logic sm_re_ff;
    logic sm_se_ff;
    logic sm_en_ff;
    logic sm_bg_ff;
    logic sm_written_ff;
    logic debug_ff;
    logic [1:0] irq_status_ff;
    logic [1:0] irq_mask_ff;
    logic [2:0] slow_sync_ff;
    logic [2:0] trim_sync_ff;
    logic [2:0] lvd_sync_ff;
    logic [2:0] stop_sync_ff;
    logic slow_level_ff;
    logic trim_level_ff;
    logic lvd_level_ff;
    logic stop_level_ff;
    logic [4:0] trim_div_ff;
    logic [10:0] wk_count_ff;
    logic tick;
    logic wk_timeout;
    logic lvd_event;
    logic monitor_on;
    logic [10:0] period_len;
    logic [7:0] wk_read;
    logic [7:0] sm_read;
    logic [31:0] nxt_prdata;

    // period decode used by the counter
    function automatic logic [10:0] period_of(input logic [2:0] sel);
        case (sel)
            3'h1: period_of = PERIOD_8MS;
            3'h2: period_of = PERIOD_32MS;
            3'h3: period_of = PERIOD_64MS;
            3'h4: period_of = PERIOD_128MS;
            3'h5: period_of = PERIOD_256MS;
            3'h6: period_of = PERIOD_512MS;
            3'h7: period_of = PERIOD_1024MS;
            default: period_of = PERIOD_NONE;
        endcase
    endfunction

    // zero-wait slave: every access completes in its first access cycle
    // decode is exact: writes to any other offset are dropped
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;

    // three-stage synchronisers for pin-side inputs
    // stage zero feeds stage one only, never any logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_sync_ff <= 3'h0;
            trim_sync_ff <= 3'h0;
            lvd_sync_ff <= 3'h0;
            stop_sync_ff <= 3'h0;
        end else begin
            slow_sync_ff <= {slow_sync_ff[1:0], slow_osc_clk};
            trim_sync_ff <= {trim_sync_ff[1:0], trim_osc_clk};
            lvd_sync_ff <= {lvd_sync_ff[1:0], low_voltage_detect};
            stop_sync_ff <= {stop_sync_ff[1:0], stop_mode};
        end
    end

    // filtered levels: change only when stages one and two agree
    // a one-cycle glitch never reaches the edge detectors
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_level_ff <= 1'b0;
            trim_level_ff <= 1'b0;
            lvd_level_ff <= 1'b0;
            stop_level_ff <= 1'b0;
        end else begin
            if (slow_sync_ff[1] == slow_sync_ff[2]) slow_level_ff <= slow_sync_ff[2];
            if (trim_sync_ff[1] == trim_sync_ff[2]) trim_level_ff <= trim_sync_ff[2];
            if (lvd_sync_ff[1] == lvd_sync_ff[2]) lvd_level_ff <= lvd_sync_ff[2];
            if (stop_sync_ff[1] == stop_sync_ff[2]) stop_level_ff <= stop_sync_ff[2];
        end
    end

    // rising edges of the filtered levels; trimmed clock divided down for its tick
    // divider free-runs, so the first trimmed tick after a select may come early
    logic slow_prev_ff;
    logic trim_prev_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_prev_ff <= 1'b0;
            trim_prev_ff <= 1'b0;
            trim_div_ff <= 5'h00;
        end else begin
            slow_prev_ff <= slow_level_ff;
            trim_prev_ff <= trim_level_ff;
            if (trim_level_ff & ~trim_prev_ff) begin
                trim_div_ff <= trim_div_ff + 5'h01;
            end
        end
    end

    logic trim_tick;
    assign trim_tick = trim_level_ff & ~trim_prev_ff & (trim_div_ff == 5'(TRIM_DIVIDE - 1));
    assign tick = wk_clksel_ff ? trim_tick : (slow_level_ff & ~slow_prev_ff);
    assign period_len = period_of(wk_period_ff);
    // >= so a period cut short mid-count fires on the next tick instead of wrapping
    assign wk_timeout = tick & (wk_period_ff != 3'h0) & (wk_count_ff >= period_len - 11'd1);

    // wakeup counter, held at zero while disabled
    // it keeps running while the flag is up; only software clears the flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wk_count_ff <= 11'h000;
        end else if (wk_period_ff == 3'h0) begin
            wk_count_ff <= 11'h000;
        end else if (wk_timeout) begin
            wk_count_ff <= 11'h000;
        end else if (tick) begin
            wk_count_ff <= wk_count_ff + 11'd1;
        end
    end

    // wakeup flag: timeout set wins over acknowledge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wk_flag_ff <= 1'b0;
        end else if (wk_timeout) begin
            wk_flag_ff <= 1'b1;
        end else if (wr_en && paddr == ADDR_WAKEUP && pwdata[WK_ACK_BIT]) begin
            wk_flag_ff <= 1'b0;
        end
    end

    // wakeup control read/write fields
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wk_clksel_ff <= 1'b0;
            wk_ie_ff <= 1'b0;
            wk_period_ff <= PERIOD_RESET;
        end else if (wr_en && paddr == ADDR_WAKEUP) begin
            wk_clksel_ff <= pwdata[WK_CLKSEL_BIT];
            wk_ie_ff <= pwdata[WK_IE_BIT];
            wk_period_ff <= pwdata[WK_PERIOD_LSB +: 3];
        end
    end

    // monitor runs when enabled and, in stop, only if stop enable is set
    assign monitor_on = sm_en_ff & (~stop_level_ff | sm_se_ff);
    logic lvd_prev_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvd_prev_ff <= 1'b0;
        end else begin
            lvd_prev_ff <= lvd_level_ff;
        end
    end
    // only the rising edge counts, so a supply held low flags once
    assign lvd_event = monitor_on & lvd_level_ff & ~lvd_prev_ff;

    // supply flag: detection wins over acknowledge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sm_flag_ff <= 1'b0;
        end else if (lvd_event) begin
            sm_flag_ff <= 1'b1;
        end else if (wr_en && paddr == ADDR_SUPPLY && pwdata[SM_ACK_BIT]) begin
            sm_flag_ff <= 1'b0;
        end
    end

    // write-once fields lock after the first write; others stay writable
    // the lock arms on any write, so the first write must carry every field
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sm_ie_ff <= 1'b0;
            sm_re_ff <= SUPPLY_RE_RESET;
            sm_se_ff <= SUPPLY_SE_RESET;
            sm_en_ff <= SUPPLY_EN_RESET;
            sm_bg_ff <= 1'b0;
            sm_written_ff <= 1'b0;
        end else if (wr_en && paddr == ADDR_SUPPLY) begin
            sm_ie_ff <= pwdata[SM_IE_BIT];
            sm_se_ff <= pwdata[SM_SE_BIT];
            sm_bg_ff <= pwdata[SM_BG_BIT];
            sm_written_ff <= 1'b1;
            if (!sm_written_ff) begin
                sm_re_ff <= pwdata[SM_RE_BIT];
                sm_en_ff <= pwdata[SM_EN_BIT];
            end
        end
    end

    // debug pin enable may be cleared once, never set by software
    // writes of one are ignored so stray code cannot reopen the pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            debug_ff <= DEBUG_PIN_RESET;
        end else if (wr_en && paddr == ADDR_DEBUG && !pwdata[0]) begin
            debug_ff <= 1'b0;
        end
    end

    // sticky interrupt status: events win over the clearing read
    logic [1:0] irq_event;
    assign irq_event[IRQ_WAKEUP_BIT] = wk_timeout;
    assign irq_event[IRQ_SUPPLY_BIT] = lvd_event;
    for (genvar gi = 0; gi < 2; gi++) begin : g_irq_status
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                irq_status_ff[gi] <= 1'b0;
            end else if (irq_event[gi]) begin
                irq_status_ff[gi] <= 1'b1;
            end else if (rd_en && paddr == ADDR_IRQ_STATUS) begin
                irq_status_ff[gi] <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_ff <= IRQ_MASK_RESET;
        end else if (wr_en && paddr == ADDR_IRQ_MASK) begin
            irq_mask_ff <= pwdata[1:0];
        end
    end

    // read views; acknowledge bits always read zero
    assign wk_read = {wk_flag_ff, 1'b0, wk_clksel_ff, wk_ie_ff, 1'b0, wk_period_ff};
    assign sm_read = {sm_flag_ff, 1'b0, sm_ie_ff, sm_re_ff, sm_se_ff, sm_en_ff, 1'b0, sm_bg_ff};

    always_comb begin
        nxt_prdata = 32'h0000_0000;
        case (paddr)
            ADDR_PART_HIGH: nxt_prdata = {24'h0, REVISION, PART_CODE[11:8]};
            ADDR_PART_LOW: nxt_prdata = {24'h0, PART_CODE[7:0]};
            ADDR_WAKEUP: nxt_prdata = {24'h0, wk_read};
            ADDR_SUPPLY: nxt_prdata = {24'h0, sm_read};
            ADDR_DEBUG: nxt_prdata = {31'h0, debug_ff};
            ADDR_IRQ_STATUS: nxt_prdata = {30'h0, irq_status_ff};
            ADDR_IRQ_MASK: nxt_prdata = {30'h0, irq_mask_ff};
            default: nxt_prdata = 32'h0000_0000;
        endcase
    end

    logic unmapped;
    assign unmapped = (paddr > ADDR_IRQ_MASK) | (paddr[1:0] != 2'h0);

    // registered answer: data and ready valid during the access cycle
    // taken from the setup phase so no path runs from paddr to pready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end else begin
            prdata <= nxt_prdata;
            pslverr <= psel & ~penable & unmapped;
            pready <= psel & ~penable;
        end
    end

    // wakeup side outputs, one cycle behind their state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wakeup_irq <= 1'b0;
            slow_osc_enable <= 1'b1;
        end else begin
            wakeup_irq <= wk_flag_ff & wk_ie_ff;
            // oscillator may stop in stop mode only with period zero and trimmed source
            slow_osc_enable <= ~(stop_level_ff & wk_clksel_ff & (wk_period_ff == 3'h0));
        end
    end

    // supply monitor side outputs, all but the bandgap buffer enable qualified by the monitor enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            supply_irq <= 1'b0;
            supply_reset_req <= 1'b0;
            supply_monitor_active <= 1'b0;
            bandgap_buffer_enable <= 1'b0;
        end else begin
            supply_irq <= sm_flag_ff & sm_ie_ff & sm_en_ff;
            supply_reset_req <= sm_flag_ff & sm_re_ff & sm_en_ff;
            supply_monitor_active <= monitor_on;
            bandgap_buffer_enable <= sm_bg_ff;
        end
    end

    // debug pin option follows its register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            debug_pin_enable <= DEBUG_PIN_RESET;
        end else begin
            debug_pin_enable <= debug_ff;
        end
    end

    // level interrupt from unmasked sticky status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status_ff & irq_mask_ff);
        end
    end
endmodule
`default_nettype wire

// ===== rtl/sysctl_pkg.sv
// package: offsets, field positions, reset values and timing for the system control bank
// Operation
// - read-only hard-wired 12-bit part code
// - fixed 4-bit revision in high bits
// - wakeup flag set at period end
// - writing one to acknowledge clears wakeup flag
// - clock select: slow oscillator or trimmed/32
// - wakeup interrupt enable bit
// - period field selects timeout, zero disables
// - wakeup interrupt pending when flag and enable
// - monitor flag set on detection while enabled
// - writing one to acknowledge clears monitor flag
// - monitor interrupt while flag and enable set
// - reset forced when reset enable and flag
// - stop enable keeps monitor active in stop
// - monitor enable qualifies flag, reset, stop
// - bandgap buffer enable output
// - write-once bits take first write only
// - debug pin enable may only fall
package sysctl_pkg;
    // register byte addresses
    localparam logic [11:0] ADDR_PART_HIGH = 12'h000;
    localparam logic [11:0] ADDR_PART_LOW = 12'h004;
    localparam logic [11:0] ADDR_WAKEUP = 12'h008;
    localparam logic [11:0] ADDR_SUPPLY = 12'h00C;
    localparam logic [11:0] ADDR_DEBUG = 12'h010;
    localparam logic [11:0] ADDR_IRQ_STATUS = 12'h014;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h018;
    // wakeup control fields
    localparam int WK_FLAG_BIT = 7;
    localparam int WK_ACK_BIT = 6;
    localparam int WK_CLKSEL_BIT = 5;
    localparam int WK_IE_BIT = 4;
    localparam int WK_PERIOD_LSB = 0;
    // supply monitor fields
    localparam int SM_FLAG_BIT = 7;
    localparam int SM_ACK_BIT = 6;
    localparam int SM_IE_BIT = 5;
    localparam int SM_RE_BIT = 4;
    localparam int SM_SE_BIT = 3;
    localparam int SM_EN_BIT = 2;
    localparam int SM_BG_BIT = 0;
    // interrupt status layout
    localparam int IRQ_WAKEUP_BIT = 0;
    localparam int IRQ_SUPPLY_BIT = 1;
    // reset values
    localparam logic [2:0] PERIOD_RESET = 3'h0;
    localparam logic DEBUG_PIN_RESET = 1'b1;
    localparam logic SUPPLY_EN_RESET = 1'b1;
    localparam logic SUPPLY_RE_RESET = 1'b1;
    localparam logic SUPPLY_SE_RESET = 1'b0;
    localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
    // timing
    localparam int TRIM_DIVIDE = 32;
    localparam logic [10:0] PERIOD_8MS = 11'd8;
    localparam logic [10:0] PERIOD_32MS = 11'd32;
    localparam logic [10:0] PERIOD_64MS = 11'd64;
    localparam logic [10:0] PERIOD_128MS = 11'd128;
    localparam logic [10:0] PERIOD_256MS = 11'd256;
    localparam logic [10:0] PERIOD_512MS = 11'd512;
    localparam logic [10:0] PERIOD_1024MS = 11'd1024;
    localparam logic [10:0] PERIOD_NONE = 11'd0;
endpackage

// ===== test/sysctl_regs_checker.sv
// checker: port-level properties of the system control register bank
`timescale 1ns/10ps
`default_nettype none
module sysctl_regs_checker
    import sysctl_pkg::*;
#(
    parameter logic [11:0] PART_CODE = 12'h5A3,
    parameter logic [3:0] REVISION = 4'h1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic wakeup_irq,
    input wire logic bandgap_buffer_enable,
    input wire logic debug_pin_enable
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // completed access strobes, split by direction
    logic rd_acc;
    logic wr_acc;
    assign rd_acc = psel && penable && pready && !pwrite;
    assign wr_acc = psel && penable && pready && pwrite;
    a_ready_zero_wait: assert property (psel && !penable |=> pready)
        else $error("access cycle without ready");
    a_part_low: assert property (
        rd_acc && paddr == ADDR_PART_LOW |-> prdata == {24'h000000, PART_CODE[7:0]})
        else $error("low part code wrong");
    a_part_high: assert property (
        rd_acc && paddr == ADDR_PART_HIGH |-> prdata == {24'h000000, REVISION, PART_CODE[11:8]})
        else $error("revision or upper part code wrong");
    a_ack_reads_zero: assert property (
        rd_acc && (paddr == ADDR_WAKEUP || paddr == ADDR_SUPPLY) |-> !prdata[6])
        else $error("acknowledge bit read back as one");
    a_unmapped_err: assert property (
        psel && penable && pready && (paddr > ADDR_IRQ_MASK || paddr[1:0] != 2'b00)
        |-> pslverr && prdata == 32'h00000000)
        else $error("unmapped access not refused");
    a_debug_no_rise: assert property (!debug_pin_enable |=> !debug_pin_enable)
        else $error("debug pin enable rose without reset");
    a_wake_irq_drop: assert property (
        wr_acc && paddr == ADDR_WAKEUP && (pwdata[6] || !pwdata[4]) |-> ##[1:3] !wakeup_irq)
        else $error("wakeup interrupt stayed after ack or disable");
    a_wake_irq_src: assert property (
        rd_acc && paddr == ADDR_WAKEUP && wakeup_irq && $past(wakeup_irq)
        |-> prdata[7] && prdata[4])
        else $error("wakeup interrupt without flag and enable");
    a_bandgap_on: assert property (
        wr_acc && paddr == ADDR_SUPPLY && pwdata[0] |-> ##[1:2] bandgap_buffer_enable)
        else $error("bandgap buffer not enabled");
endmodule
bind sysctl_regs sysctl_regs_checker #(.PART_CODE(PART_CODE), .REVISION(REVISION)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wakeup_irq(wakeup_irq), .bandgap_buffer_enable(bandgap_buffer_enable),
    .debug_pin_enable(debug_pin_enable));
`default_nettype wire

// ===== test/sysctl_regs_tb.sv
// testbench: apb scenarios for the system control register bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end
module sysctl_regs_tb;
    import sysctl_pkg::*;
    localparam logic [11:0] PC = 12'h3C7; // value arbitrary
    localparam logic [3:0] RV = 4'h2; // value arbitrary
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr, slow = 1'b0, trim = 1'b0, supply_monitor = 1'b0, stop = 1'b0;
    logic wk_irq, sup_irq, sup_rst, sup_act, bg_en, dbg_en, osc_en, irq;
    logic [32:0] exp_q[$];
    logic [32:0] e;
    int n_mismatch = 0, samples_checked = 0, cyc = 0;
    sysctl_regs #(.PART_CODE(PC), .REVISION(RV)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .slow_osc_clk(slow),
        .trim_osc_clk(trim), .low_voltage_detect(supply_monitor), .stop_mode(stop),
        .wakeup_irq(wk_irq), .supply_irq(sup_irq), .supply_reset_req(sup_rst),
        .supply_monitor_active(sup_act), .bandgap_buffer_enable(bg_en),
        .debug_pin_enable(dbg_en), .slow_osc_enable(osc_en), .irq(irq));
    always #2.5 pclk = ~pclk;
    // read results arrive one per completed read access, oldest note first
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            e = exp_q.pop_front();
            `CHK("read data", e, {pslverr, prdata})
        end
    end
    // hang guard: the full run needs about 3300 cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // one apb transfer; request held until ready is sampled high
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] x);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        if (!w) exp_q.push_back(x);
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 33'h0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] x);
        bus(1'b0, a, $urandom, {25'h0, x});
    endtask
    // oscillator edges, slowed to survive the input synchronisers
    task automatic osc(input int n, input bit t);
        repeat (n) begin
            repeat (6) @(posedge pclk);
            if (t) trim <= 1'b1; else slow <= 1'b1;
            repeat (6) @(posedge pclk);
            if (t) trim <= 1'b0; else slow <= 1'b0;
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge pclk);
    endtask
    initial begin
        void'($urandom(32'hcaac));
        wait_n(5);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK("debug reset", 1'b1, dbg_en)
        rd(ADDR_PART_HIGH, {RV, PC[11:8]});
        rd(ADDR_PART_LOW, PC[7:0]);
        wr(ADDR_PART_HIGH, $urandom);
        wr(ADDR_PART_LOW, $urandom);
        rd(ADDR_PART_HIGH, {RV, PC[11:8]});
        rd(ADDR_PART_LOW, PC[7:0]);
        bus(1'b0, 12'h01C, 32'h0, {1'b1, 32'h0});
        bus(1'b0, 12'h006, 32'h0, {1'b1, 32'h0});
        // slow source, shortest period, interrupt on
        wr(ADDR_WAKEUP, 32'h00000011);
        osc(7, 1'b0);
        `CHK("wakeup early", 1'b0, wk_irq)
        osc(1, 1'b0);
        wait_n(2);
        `CHK("wakeup due", 1'b1, wk_irq)
        rd(ADDR_WAKEUP, 8'h91);
        wr(ADDR_IRQ_MASK, 32'h00000001);
        wait_n(3);
        `CHK("irq line", 1'b1, irq)
        rd(ADDR_IRQ_STATUS, 8'h01);
        rd(ADDR_IRQ_STATUS, 8'h00);
        wr(ADDR_WAKEUP, 32'h00000051);
        rd(ADDR_WAKEUP, 8'h11);
        // trimmed source divided by 32, interrupt off
        wr(ADDR_WAKEUP, 32'h00000021);
        osc(255, 1'b1);
        rd(ADDR_WAKEUP, 8'h21);
        osc(1, 1'b1);
        rd(ADDR_WAKEUP, 8'hA1);
        `CHK("wakeup masked", 1'b0, wk_irq)
        wr(ADDR_WAKEUP, 32'h00000060);
        stop <= 1'b1;
        wait_n(10);
        `CHK("osc power", 1'b0, osc_en)
        stop <= 1'b0;
        // supply monitor with reset enable from reset
        supply_monitor <= 1'b1;
        wait_n(10);
        `CHK("supply reset", 1'b1, sup_rst)
        `CHK("supply irq off", 1'b0, sup_irq)
        supply_monitor <= 1'b0;
        wr(ADDR_SUPPLY, 32'h0000006D);
        wait_n(3);
        `CHK("reset cleared", 1'b0, sup_rst)
        rd(ADDR_SUPPLY, 8'h2D);
        wr(ADDR_SUPPLY, 32'h00000031);
        rd(ADDR_SUPPLY, 8'h25);
        `CHK("bandgap", 1'b1, bg_en)
        supply_monitor <= 1'b1;
        wait_n(10);
        `CHK("supply irq", 1'b1, sup_irq)
        `CHK("reset locked", 1'b0, sup_rst)
        stop <= 1'b1;
        wait_n(10);
        `CHK("stop off", 1'b0, sup_act)
        wr(ADDR_IRQ_MASK, 32'h00000002);
        wait_n(3);
        `CHK("irq supply", 1'b1, irq)
        rd(ADDR_IRQ_STATUS, 8'h03); // trimmed timeout left bit 0 set too
        wr(ADDR_DEBUG, 32'h00000000);
        wr(ADDR_DEBUG, 32'h00000001);
        rd(ADDR_DEBUG, 8'h00);
        `CHK("debug pin", 1'b0, dbg_en)
        // second reset restores the debug option and re-arms the write-once bits
        supply_monitor <= 1'b0;
        stop <= 1'b0;
        presetn <= 1'b0;
        wait_n(2);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK("debug after reset", 1'b1, dbg_en)
        wr(ADDR_SUPPLY, 32'h00000000);
        rd(ADDR_SUPPLY, 8'h00);
        finish_test();
    end
endmodule
`default_nettype wire
